// ### inc/scdb_pkg.sv
// shared constants for the scan countdown delay bank
package scdb_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int BASE_TICK_NS = 1000000; // 1 ms reference step
   localparam int CLK_PER_MS = (BASE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] DECADE_LAST = 4'h9; // 10 steps per decade
   localparam logic [3:0] DECADE_HALF = 4'h5; // relay high from here

   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int NUM_UNITS = 256;
   localparam int NUM_DREGS = 16;
   localparam int NUM_PINS = 16;

   // ------------------------------------------------------------
   // tick base encodings (per unit)
   // ------------------------------------------------------------
   localparam logic [1:0] BASE_1MS = 2'h0;
   localparam logic [1:0] BASE_10MS = 2'h1;
   localparam logic [1:0] BASE_100MS = 2'h2;
   localparam logic [1:0] BASE_1S = 2'h3;

   // ------------------------------------------------------------
   // register map (byte addresses, 12-bit)
   // ------------------------------------------------------------
   localparam logic [1:0] REGION_MISC = 2'h0;
   localparam logic [1:0] REGION_PRESET = 2'h1;
   localparam logic [1:0] REGION_CURRENT = 2'h2;
   localparam logic [1:0] REGION_CTRL = 2'h3;
   localparam logic [7:0] MISC_STATUS = 8'h00;   // 0x000
   localparam logic [7:0] MISC_SCAN = 8'h01;     // 0x004
   localparam logic [7:0] MISC_IN_IMG = 8'h02;   // 0x008
   localparam logic [7:0] MISC_OUT_SW = 8'h03;   // 0x00c
   localparam logic [7:0] MISC_DONE_MAP = 8'h04; // 0x010
   localparam logic [7:0] MISC_OUT_PINS = 8'h05; // 0x014
   localparam logic [7:0] MISC_DREG_BASE = 8'h10; // 0x040..0x07c
   localparam logic [3:0] MISC_DREG_HI = 4'h1;   // index bits 7:4

   // ------------------------------------------------------------
   // unit control word fields
   // ------------------------------------------------------------
   localparam int CTL_PROG_EN = 0;
   localparam int CTL_USE_IN = 1;
   localparam int CTL_BASE_LO = 2;
   localparam int CTL_SRC_DREG = 4;
   localparam int CTL_IN_IDX_LO = 8;
   localparam int CTL_DREG_IDX_LO = 12;
   localparam int CTL_DONE_BIT = 31;
   localparam int SCAN_GO_BIT = 0;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [15:0] RST_WORD16 = 16'h0000;
endpackage

// ### src/scdb_tick_gen.sv
// free-running reference counters, tick phases and clock relays
`timescale 1ns/1ns
`default_nettype none

module scdb_tick_gen #(
   parameter int CLK_PER_MS = scdb_pkg::CLK_PER_MS
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   output logic [3:0] phase_o,
   output logic [2:0] relay_o,
   output logic [15:0] ms_count_o
);
   logic [15:0] pre_q;
   logic [15:0] ms_q;
   logic [3:0] c10_q;
   logic [3:0] c100_q;
   logic [3:0] c1000_q;
   logic [3:0] phase_q;
   logic [2:0] relay_q;
   logic ms_step;
   logic wrap10;
   logic wrap100;
   logic wrap1000;

   // ------------------------------------------------------------
   // step decode
   // ------------------------------------------------------------
   assign ms_step = (pre_q == 16'(CLK_PER_MS - 1));
   assign wrap10 = ms_step && (c10_q == scdb_pkg::DECADE_LAST);
   assign wrap100 = wrap10 && (c100_q == scdb_pkg::DECADE_LAST);
   assign wrap1000 = wrap100 && (c1000_q == scdb_pkg::DECADE_LAST);

   // prescaler and 16-bit reference ms counter, never synced to any unit
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pre_q <= 16'h0000;
         ms_q <= 16'h0000;
      end else begin
         pre_q <= ms_step ? 16'h0000 : pre_q + 16'h0001;
         ms_q <= ms_step ? ms_q + 16'h0001 : ms_q;
      end
   end

   // decade chain; each phase bit toggles once per base step
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         c10_q <= 4'h0;
         c100_q <= 4'h0;
         c1000_q <= 4'h0;
         phase_q <= 4'h0;
      end else begin
         if (ms_step) c10_q <= wrap10 ? 4'h0 : c10_q + 4'h1;
         if (wrap10) c100_q <= wrap100 ? 4'h0 : c100_q + 4'h1;
         if (wrap100) c1000_q <= wrap1000 ? 4'h0 : c1000_q + 4'h1;
         phase_q <= phase_q ^ {wrap1000, wrap100, wrap10, ms_step};
      end
   end

   // relays: half period high, 1 s / 100 ms / 10 ms
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         relay_q <= 3'h0;
      end else begin
         relay_q <= {c1000_q >= scdb_pkg::DECADE_HALF, c100_q >= scdb_pkg::DECADE_HALF,
                     c10_q >= scdb_pkg::DECADE_HALF};
      end
   end

   assign phase_o = phase_q;
   assign relay_o = relay_q;
   assign ms_count_o = ms_q;
endmodule

`default_nettype wire

// ### src/scdb_bank.sv
// bank of 256 countdown on-delay units behind a wishbone slave
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - four tick bases: 1s, 100ms, 10ms, 1ms
// - 256 independent units, indices 0 to 255
// - preset unsigned 0..65535, constant or data register
// - data register preset uses its current contents
// - counting starts once enable is true
// - done asserts when current value reaches zero
// - enable false reloads preset, clears done
// - preset change applies from next timing cycle
// - preset zero stops unit, done at once
// - current value write takes effect immediately
// - ticks from free-running 16-bit reference counters
// - inputs sampled once per scan into image
// - output image reaches pins only at end-of-scan
// - no unit state kept across power loss
// - free-running clock relays 1s, 100ms, 10ms
module scdb_bank #(
   parameter int CLK_PER_MS = scdb_pkg::CLK_PER_MS
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [15:0] in_pins_i,
   output logic [15:0] out_pins_o,
   output logic [255:0] done_o,
   output logic [2:0] relay_o
);
   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic [15:0] preset_w [0:255];
   logic [15:0] cur_w [0:255];
   logic [15:0] ctrl_w [0:255];
   logic [255:0] done_w;
   logic [255:0] seen_w;
   logic [255:0] run_w;
   logic [15:0] dreg_w [0:15];
   logic [15:0] in_img_q;
   logic [15:0] out_sw_q;
   logic [15:0] done_map_q;
   logic [15:0] out_pins_q;
   logic [15:0] scan_cnt_q;
   logic [7:0] ptr_q;
   logic ack_q;
   logic [31:0] dat_q;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   logic req;
   logic wr_go;
   logic [1:0] region;
   logic [7:0] idx;
   logic [31:0] wmask;
   logic pre_we;
   logic cur_we;
   logic ctl_we;
   logic misc_we;
   logic dreg_hit;
   logic scan_go;
   logic [31:0] rdata;
   logic [31:0] misc_rd;
   logic [3:0] phase;
   logic [15:0] ms_count;

   assign req = wb_cyc_i && wb_stb_i;
   assign wr_go = req && wb_we_i && ack_q; // write lands on the ack edge
   assign region = wb_adr_i[11:10];
   assign idx = wb_adr_i[9:2];
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign pre_we = wr_go && (region == scdb_pkg::REGION_PRESET);
   assign cur_we = wr_go && (region == scdb_pkg::REGION_CURRENT);
   assign ctl_we = wr_go && (region == scdb_pkg::REGION_CTRL);
   assign misc_we = wr_go && (region == scdb_pkg::REGION_MISC);
   assign dreg_hit = (idx[7:4] == scdb_pkg::MISC_DREG_HI);
   assign scan_go = misc_we && (idx == scdb_pkg::MISC_SCAN) && wb_sel_i[0]
                    && wb_dat_i[scdb_pkg::SCAN_GO_BIT];

   // merge a 16-bit field under the byte enables
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw,
                                           input logic [31:0] m);
      merge16 = (old & ~m[15:0]) | (nw[15:0] & m[15:0]);
   endfunction

   // ------------------------------------------------------------
   // reference ticks and clock relays
   // ------------------------------------------------------------
   scdb_tick_gen #(
      .CLK_PER_MS(CLK_PER_MS)
   ) u_tick (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .phase_o(phase),
      .relay_o(relay_o),
      .ms_count_o(ms_count)
   );

   // ------------------------------------------------------------
   // sweep: one unit visited per cycle, paused by bus writes
   // ------------------------------------------------------------
   logic [15:0] v_ctrl;
   logic [15:0] v_cur;
   logic [15:0] v_pre;
   logic [1:0] v_base;
   logic v_en;
   logic v_phase;
   logic v_tick;
   logic [15:0] v_cur_d;
   logic v_done_d;
   logic visit_go;

   assign visit_go = !wr_go;
   assign v_ctrl = ctrl_w[ptr_q];
   assign v_cur = cur_w[ptr_q];
   assign v_base = v_ctrl[scdb_pkg::CTL_BASE_LO +: 2];
   // enable is the program bit or a sampled image bit, never a live pin
   assign v_en = v_ctrl[scdb_pkg::CTL_USE_IN] ? in_img_q[v_ctrl[scdb_pkg::CTL_IN_IDX_LO +: 4]]
                 : v_ctrl[scdb_pkg::CTL_PROG_EN];
   // preset from a data register reads its live contents
   assign v_pre = v_ctrl[scdb_pkg::CTL_SRC_DREG] ? dreg_w[v_ctrl[scdb_pkg::CTL_DREG_IDX_LO +: 4]]
                  : preset_w[ptr_q];
   // a tick is any phase change since the last visit, so the first one may be early
   assign v_phase = phase[v_base];
   assign v_tick = (v_phase != seen_w[ptr_q]);

   // next value of the visited unit
   always_comb begin
      v_cur_d = v_cur;
      v_done_d = 1'b0;
      if (!v_en) begin
         v_cur_d = v_pre;
         v_done_d = 1'b0;
      end else if (v_pre == 16'h0000) begin
         v_cur_d = 16'h0000;
         v_done_d = 1'b1;
      end else if (!run_w[ptr_q]) begin
         v_cur_d = v_pre; // first enabled visit starts from the preset, not a stale reload
      end else if (v_cur == 16'h0000) begin
         v_done_d = 1'b1;
      end else if (v_tick) begin
         v_cur_d = v_cur - 16'h0001;
         v_done_d = (v_cur == 16'h0001);
      end
   end

   // sweep pointer over all units
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ptr_q <= 8'h00;
      end else if (visit_go) begin
         ptr_q <= ptr_q + 8'h01;
      end
   end

   // ------------------------------------------------------------
   // per-unit registers, all cleared by reset
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < scdb_pkg::NUM_UNITS; gi++) begin : g_unit
         logic [15:0] preset_q;
         logic [15:0] cur_q;
         logic [15:0] ctrl_q;
         logic done_q;
         logic seen_q;
         logic run_q;
         logic sel;
         logic vis;

         assign sel = (idx == 8'(gi));
         assign vis = visit_go && (ptr_q == 8'(gi));

         // preset: a bus write only lands in the store, the count runs on
         always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               preset_q <= scdb_pkg::RST_WORD16;
               ctrl_q <= scdb_pkg::RST_WORD16;
            end else begin
               if (pre_we && sel) preset_q <= merge16(preset_q, wb_dat_i, wmask);
               if (ctl_we && sel) ctrl_q <= merge16(ctrl_q, wb_dat_i, wmask);
            end
         end

         // current value: bus write wins and is seen at once
         always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               cur_q <= scdb_pkg::RST_WORD16;
               done_q <= 1'b0;
               seen_q <= 1'b0;
               run_q <= 1'b0;
            end else if (cur_we && sel) begin
               cur_q <= merge16(cur_q, wb_dat_i, wmask);
            end else if (vis) begin
               cur_q <= v_cur_d;
               done_q <= v_done_d;
               seen_q <= v_phase;
               run_q <= v_en;
            end
         end

         assign preset_w[gi] = preset_q;
         assign cur_w[gi] = cur_q;
         assign ctrl_w[gi] = ctrl_q;
         assign done_w[gi] = done_q;
         assign seen_w[gi] = seen_q;
         assign run_w[gi] = run_q;
      end

      // data registers usable as preset sources
      for (gi = 0; gi < scdb_pkg::NUM_DREGS; gi++) begin : g_dreg
         logic [15:0] dreg_q;

         always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               dreg_q <= scdb_pkg::RST_WORD16;
            end else if (misc_we && dreg_hit && (idx[3:0] == 4'(gi))) begin
               dreg_q <= merge16(dreg_q, wb_dat_i, wmask);
            end
         end

         assign dreg_w[gi] = dreg_q;
      end
   endgenerate

   // ------------------------------------------------------------
   // scan images
   // ------------------------------------------------------------
   logic [15:0] out_image;

   // done of units 0..15 may drive the matching output image bit
   assign out_image = out_sw_q | (done_w[15:0] & done_map_q);

   // software image registers
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         out_sw_q <= scdb_pkg::RST_WORD16;
         done_map_q <= scdb_pkg::RST_WORD16;
      end else begin
         if (misc_we && idx == scdb_pkg::MISC_OUT_SW) out_sw_q <= merge16(out_sw_q, wb_dat_i, wmask);
         if (misc_we && idx == scdb_pkg::MISC_DONE_MAP) done_map_q <= merge16(done_map_q, wb_dat_i, wmask);
      end
   end

   // end-of-scan: sample inputs, commit outputs, count scans
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         in_img_q <= scdb_pkg::RST_WORD16;
         out_pins_q <= scdb_pkg::RST_WORD16;
         scan_cnt_q <= scdb_pkg::RST_WORD16;
      end else if (scan_go) begin
         in_img_q <= in_pins_i;
         out_pins_q <= out_image;
         scan_cnt_q <= scan_cnt_q + 16'h0001;
      end
   end

   assign out_pins_o = out_pins_q;
   assign done_o = done_w;

   // ------------------------------------------------------------
   // read mux; unmapped words read zero
   // ------------------------------------------------------------
   logic [31:0] dreg_rd;
   logic [31:0] ctl_rd;

   assign dreg_rd = {16'h0000, dreg_w[idx[3:0]]};
   assign ctl_rd = {done_w[idx], 15'h0000, ctrl_w[idx]};
   assign misc_rd = (idx == scdb_pkg::MISC_STATUS) ? {ms_count, 5'h00, relay_o, ptr_q} :
                    (idx == scdb_pkg::MISC_SCAN) ? {16'h0000, scan_cnt_q} :
                    (idx == scdb_pkg::MISC_IN_IMG) ? {16'h0000, in_img_q} :
                    (idx == scdb_pkg::MISC_OUT_SW) ? {16'h0000, out_sw_q} :
                    (idx == scdb_pkg::MISC_DONE_MAP) ? {16'h0000, done_map_q} :
                    (idx == scdb_pkg::MISC_OUT_PINS) ? {16'h0000, out_pins_q} :
                    dreg_hit ? dreg_rd : 32'h00000000;
   assign rdata = (region == scdb_pkg::REGION_PRESET) ? {16'h0000, preset_w[idx]} :
                  (region == scdb_pkg::REGION_CURRENT) ? {16'h0000, cur_w[idx]} :
                  (region == scdb_pkg::REGION_CTRL) ? ctl_rd : misc_rd;

   // ------------------------------------------------------------
   // wishbone handshake: ack one cycle after the request, data registered
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else begin
         ack_q <= req && !ack_q;
         if (req && !ack_q) dat_q <= rdata;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
endmodule

`default_nettype wire

// ### dv/scdb_bank_properties.sv
// port assertions for the scan countdown bank
`timescale 1ns/1ns
`default_nettype none

module scdb_bank_properties #(
   parameter int CLK_PER_MS = scdb_pkg::CLK_PER_MS
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [15:0] in_pins_i,
   input wire logic [15:0] out_pins_o,
   input wire logic [255:0] done_o,
   input wire logic [2:0] relay_o
);
   localparam int HALF = 5 * CLK_PER_MS;
   logic [31:0] gap_q;
   logic rel_q;
   logic seen_q;
   // end-of-scan write landing at this edge
   wire logic scan_hit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & (wb_adr_i[11:2] == 10'h001) & wb_sel_i[0]
      & wb_dat_i[0];

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   // cycles since the 10 ms relay last moved
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         gap_q <= 32'h0;
         rel_q <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         rel_q <= relay_o[0];
         gap_q <= (relay_o[0] != rel_q) ? 32'h0 : gap_q + 32'h1;
         seen_q <= seen_q | (relay_o[0] != rel_q);
      end
   end

   // ------------------------------------------------------------
   // bus and output checks
   // ------------------------------------------------------------
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   a_ack_latency: assert property (s_req |=> wb_ack_o) else $error("ack missing after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   a_data_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("read data moved without ack");
   a_pins_at_scan: assert property ($changed(out_pins_o) |-> $past(scan_hit)) else $error("pins moved off scan");
   a_pins_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 12'h014 |-> wb_dat_o[15:0] == out_pins_o)
      else $error("pin register differs from pins");
   a_hole_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[11:6] == 6'h00 && wb_adr_i[5:2] > 4'h5
      |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   a_relay_half: assert property (seen_q && relay_o[0] != rel_q |-> gap_q == HALF - 1)
      else $error("relay half period wrong");
   a_relay_bound: assert property (seen_q |-> gap_q < HALF) else $error("relay stopped");
endmodule

bind scdb_bank scdb_bank_properties #(.CLK_PER_MS(CLK_PER_MS)) chk_u (.clk_i(clk_i), .nrst_i(nrst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .in_pins_i(in_pins_i),
   .out_pins_o(out_pins_o), .done_o(done_o), .relay_o(relay_o));
`default_nettype wire

// ### dv/scdb_scan_exec.sv
// scan executor model issuing register cycles to the bank
`timescale 1ns/1ns
`default_nettype none

module scdb_scan_exec (
   input wire logic clk_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_i,
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [11:0] wb_adr_o,
   output logic [3:0] wb_sel_o,
   output logic [31:0] wb_dat_o
);
   // idle bus at time zero
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o = 1'b0;
      wb_adr_o = 12'h000;
      wb_sel_o = 4'hf;
      wb_dat_o = 32'h0;
   end

   // one classic cycle; only legal follow-on operations are issued
   task automatic xfer(input logic we, input logic [11:0] adr, input logic [31:0] dat, output logic [31:0] rd);
      @(posedge clk_i);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= we;
      wb_sel_o <= 4'hf;
      wb_adr_o <= adr;
      wb_dat_o <= dat;
      do begin
         @(posedge clk_i);
      end while (wb_ack_i !== 1'b1);
      rd = wb_dat_i;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o <= 1'b0;
      wb_dat_o <= ~dat; // stale data not kept
   endtask
endmodule
`default_nettype wire

// ### dv/test_scan_countdown_delay_bank.sv
// self-checking bench for the scan countdown bank
`timescale 1ns/1ns
`default_nettype none

module test_scan_countdown_delay_bank;
   localparam int CPM = 500;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [15:0] in_pins_i = 16'h0000;
   wire logic cyc, stb, we, ack;
   wire logic [11:0] adr;
   wire logic [3:0] sel;
   wire logic [31:0] wdat, rdat;
   wire logic [15:0] pins;
   wire logic [255:0] done;
   wire logic [2:0] relay;
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int t0 = 0;
   int mdl_pre[256];
   int pend[$];
   logic [31:0] seed = 32'h0000002d;
   logic [31:0] rd, v;

   scdb_bank #(.CLK_PER_MS(CPM)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .in_pins_i(in_pins_i), .out_pins_o(pins), .done_o(done), .relay_o(relay));
   scdb_scan_exec exec_u (.clk_i(clk_i), .wb_dat_i(rdat), .wb_ack_i(ack), .wb_cyc_o(cyc), .wb_stb_o(stb),
      .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));

   // clock and hang limit
   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         num_errors++;
         stop_test();
      end
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [11:0] ua(input logic [1:0] r, input int i);
      return {r, i[7:0], 2'h0};
   endfunction
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      exec_u.xfer(1'b1, a, d, rd);
   endtask
   task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
      exec_u.xfer(1'b0, a, 32'h0, rd);
      check(what, exp, rd);
   endtask
   task automatic setp(input int u, input logic [15:0] p);
      mdl_pre[u] = p;
      wr(ua(2'h1, u), {16'h0, p});
   endtask
   // done must rise inside a window counted from t0
   task automatic wait_done(input int u, input int lo, input int hi);
      while (done[u] !== 1'b1 && cycles - t0 < hi) begin
         @(posedge clk_i);
      end
      check("done window", 32'h1, {31'h0, done[u] === 1'b1 && cycles - t0 >= lo});
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      check("reset done", 32'h0, {31'h0, |done});
      for (int k = 0; k < 4; k++) begin
         v = xs();
         pend.push_back(v[15:0]);
         setp(255 - k, v[15:0]);
      end
      for (int k = 0; k < 4; k++) begin
         rdc("preset", ua(2'h1, 255 - k), pend.pop_front());
      end
      setp(0, 16'hffff);
      rdc("preset max", ua(2'h1, 0), mdl_pre[0]);
      rdc("hole", 12'h020, 32'h0);
      // one unit per tick base, preset 2
      t0 = cycles;
      for (int b = 0; b < 4; b++) begin
         setp(8 + b, 16'h2);
         wr(ua(2'h3, 8 + b), 32'h1 | (b << 2));
      end
      wait_done(8, CPM - 260, 2 * CPM + 600);
      wait_done(9, 10 * CPM - 260, 20 * CPM + 600);
      check("slow bases", 32'h0, {30'h0, done[11:10]});
      wr(ua(2'h3, 8), 32'h0);
      repeat (300) @(posedge clk_i);
      check("done cleared", 32'h0, {31'h0, done[8]});
      rdc("reload", ua(2'h2, 8), mdl_pre[8]);
      // preset change mid-run, then current edit
      setp(20, 16'h3e8);
      wr(ua(2'h3, 20), 32'h1);
      repeat (1500) @(posedge clk_i);
      setp(20, 16'h4);
      exec_u.xfer(1'b0, ua(2'h2, 20), 32'h0, rd);
      check("running", 32'h1, {31'h0, rd > 32'h3e2 && rd < 32'h3e8});
      wr(ua(2'h2, 20), 32'h3);
      t0 = cycles;
      wait_done(20, 2 * CPM - 260, 3 * CPM + 600);
      wr(ua(2'h3, 20), 32'h0);
      repeat (300) @(posedge clk_i);
      rdc("new preset", ua(2'h2, 20), mdl_pre[20]);
      // preset to zero stops the unit
      setp(21, 16'h3e8);
      wr(ua(2'h3, 21), 32'h1);
      repeat (600) @(posedge clk_i);
      setp(21, 16'h0);
      t0 = cycles;
      wait_done(21, 0, 300);
      // preset from a data register
      wr(12'h054, 32'h7);
      wr(ua(2'h3, 22), 32'h5010);
      repeat (300) @(posedge clk_i);
      rdc("dreg preset", ua(2'h2, 22), 32'h7);
      // enable from the input image, done to pins
      wr(ua(2'h3, 1), 32'h0202);
      v = xs() | 32'h4;
      in_pins_i <= v[15:0];
      repeat (300) @(posedge clk_i);
      check("image gate", 32'h0, {31'h0, done[1]});
      wr(12'h004, 32'h1);
      rdc("image", 12'h008, {16'h0, v[15:0]});
      repeat (300) @(posedge clk_i);
      check("image done", 32'h1, {31'h0, done[1]});
      v = xs();
      wr(12'h010, 32'h2);
      wr(12'h00c, v);
      check("pins held", 32'h0, {16'h0, pins});
      wr(12'h004, 32'h1);
      rdc("pins", 12'h014, {16'h0, v[15:0] | 16'h2});
      check("pin port", {16'h0, v[15:0] | 16'h2}, {16'h0, pins});
      // reset in mid-run keeps nothing
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      check("reset pins", 32'h0, {16'h0, pins});
      check("reset done", 32'h0, {31'h0, |done});
      rdc("reset preset", ua(2'h1, 20), 32'h0);
      stop_test();
   end
endmodule
`default_nettype wire
